//--- inc/ptu_regs.svh
// register offsets, field positions, reset values and divider taps of the clock/clear select
`ifndef PTU_REGS_SVH
`define PTU_REGS_SVH

`define PTU_OFF_CTRL0 4'h0
`define PTU_OFF_CTRL5 4'h5
`define PTU_OFF_SYNC 4'h6
`define PTU_OFF_PHASE 4'h7
`define PTU_OFF_BUFFER 4'h8
`define PTU_OFF_CLRFLAG 4'h9

`define PTU_CLR_HI 7
`define PTU_CLR_LO 5
`define PTU_EDGE_HI 4
`define PTU_EDGE_LO 3
`define PTU_PSC_HI 2
`define PTU_PSC_LO 0

`define PTU_BUF_A0 0
`define PTU_BUF_B0 1
`define PTU_BUF_A3 2
`define PTU_BUF_B3 3

`define PTU_CTRL_RST 8'h00
`define PTU_SYNC_RST 6'h00
`define PTU_PHASE_RST 6'h00
`define PTU_BUFFER_RST 4'h0
`define PTU_FLAG_RST 6'h00

`define PTU_PHASE_MASK 6'h36
`define PTU_WIDE_MASK 6'h09

`define PTU_PRE_WIDTH 12
`define PTU_TAPS 6

`endif

//--- inc/ptu_pkg.sv
// types shared by the clock/clear select block
package ptu_pkg;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ptu_bus_s;

  typedef struct packed {
    logic [5:0] reg_a;
    logic [5:0] reg_b;
    logic [5:0] reg_c;
    logic [5:0] reg_d;
  } ptu_match_s;

  typedef struct packed {
    logic rise;
    logic fall;
  } ptu_edge_s;

  typedef logic [2:0] ptu_code_t;

endpackage

//--- logic/ptu_prescaler.sv
// free-running divider giving rise and fall pulses of the phi/4 .. phi/4096 taps
`timescale 1ns/1ns
`include "ptu_regs.svh"

module ptu_prescaler #(
  parameter int PRE_W = `PTU_PRE_WIDTH
) (
  input wire logic clk,
  input wire logic reset_n,
  output ptu_pkg::ptu_edge_s [`PTU_TAPS-1:0] tap_q
);

  initial begin
    if (PRE_W < 2 * `PTU_TAPS) begin
      $error("ptu_prescaler: PRE_W too small for the phi/4096 tap");
    end
  end

  logic [PRE_W-1:0] cnt_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // tap i divides by 4**(i+1); its square wave is cnt bit 2i+1
  for (genvar i = 0; i < `PTU_TAPS; i++) begin : g_tap
    localparam int K = 2 * (i + 1);
    wire [K-1:0] low = cnt_q[K-1:0];
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        tap_q[i] <= '0;
      end else begin
        tap_q[i].rise <= (low == {1'b0, {(K-1){1'b1}}});
        tap_q[i].fall <= (&low);
      end
    end
  end

endmodule

//--- logic/ptu_pin_edge.sv
// two-stage synchroniser and edge detector for one external clock pin
`timescale 1ns/1ns

module ptu_pin_edge (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic pin,
  output ptu_pkg::ptu_edge_s edge_q
);

  logic meta_q;
  logic sync_q;
  logic last_q;

  // meta_q feeds sync_q only, so a metastable sample never reaches the edge logic
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      meta_q <= pin;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      edge_q <= '0;
    end else begin
      edge_q.rise <= sync_q & ~last_q; // R18
      edge_q.fall <= ~sync_q & last_q; // R18
    end
  end

endmodule

//--- logic/ptu_clock_clear.sv
// clock source and counter clear selection for the six channels of the pulse timer unit
// Function
// R1: wide channels: 000/100 none, 001 A, 010 B
// R2: wide channels: 101 clears on C, 110 on D
// R3: x11 clears with another synchronous channel
// R4: synchronous only when its synchro bit is 1
// R5: buffered C or D never clears
// R6: narrow channels: control bit 7 reads 0
// R7: narrow channels: 00 none, 01 A, 10 B, 11 sync
// R8: codes 000-011 count phi/1, /4, /16, /64
// R9: channel 0: 100-111 count pins A-D
// R10: channel 1: pins A, B, phi/256, channel 2 overflow
// R11: channel 2: pins A, B, C, phi/1024
// R12: channel 3: pin A, phi/1024, /256, /4096
// R13: channel 4: pins A, C, phi/1024, channel 5 overflow
// R14: channel 5: pins A, C, phi/256, pin D
// R15: phase counting overrides prescaler on narrow channels
// R16: edge 00 rising, 01 falling, 1x both
// R17: software changes selection only while stopped
// R18: pins synchronised, one pulse per edge
//
// Implementation choices: the strobed register port and the register addresses.
`timescale 1ns/1ns
`include "ptu_regs.svh"

module ptu_clock_clear #(
  parameter int PRE_W = `PTU_PRE_WIDTH
) (
  input wire logic clk,
  input wire logic reset_n,
  input ptu_pkg::ptu_bus_s bus,
  output logic [7:0] rdata_q,
  input wire logic [3:0] ext_clock_pin,
  input ptu_pkg::ptu_match_s match,
  input wire logic [5:0] phase_count,
  input wire logic channel_two_wrap,
  input wire logic channel_five_wrap,
  output logic [5:0] count_en_q,
  output logic [5:0] clear_q
);

  localparam int NCH = 6;

  initial begin
    if (PRE_W < 2 * `PTU_TAPS) begin
      $error("ptu_clock_clear: PRE_W too small");
    end
  end

  logic [7:0] counter_control_q [NCH];
  logic [5:0] synchro_register_q;
  logic [5:0] phase_mode_q;
  logic [3:0] buffer_mode_q;
  logic [5:0] clear_flag_q;

  ptu_pkg::ptu_edge_s [`PTU_TAPS-1:0] tap;
  ptu_pkg::ptu_edge_s [3:0] pin_edge;

  logic [5:0] own_clear;
  logic [5:0] sync_pick;
  logic [5:0] clear_d;
  logic [5:0] count_d;
  logic [5:0] wide_ch;

  assign wide_ch = `PTU_WIDE_MASK;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------

  function automatic logic edge_pick(input ptu_pkg::ptu_edge_s e, input logic [1:0] sel);
    logic r;
    r = 1'b0;
    if (sel[1]) begin
      r = e.rise | e.fall; // R16
    end else if (sel[0]) begin
      r = e.fall; // R16
    end else begin
      r = e.rise; // R16
    end
    return r;
  endfunction

  function automatic logic is_ctrl(input logic [3:0] a);
    return (a >= `PTU_OFF_CTRL0) && (a <= `PTU_OFF_CTRL5);
  endfunction

  // ---------------------------------------------------------------
  // divider and pin edge detectors
  // ---------------------------------------------------------------

  ptu_prescaler #(
    .PRE_W(PRE_W)
  ) u_prescaler (
    .clk(clk),
    .reset_n(reset_n),
    .tap_q(tap)
  );

  for (genvar p = 0; p < 4; p++) begin : g_pin
    ptu_pin_edge u_pin (
      .clk(clk),
      .reset_n(reset_n),
      .pin(ext_clock_pin[p]),
      .edge_q(pin_edge[p])
    );
  end

  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------

  for (genvar c = 0; c < NCH; c++) begin : g_ctrl
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        counter_control_q[c] <= `PTU_CTRL_RST;
      end else if (bus.wr && bus.addr == 4'(c)) begin
        counter_control_q[c] <= bus.wdata;
        if (!wide_ch[c]) begin
          counter_control_q[c][`PTU_CLR_HI] <= 1'b0; // R6
        end
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      synchro_register_q <= `PTU_SYNC_RST;
    end else if (bus.wr && bus.addr == `PTU_OFF_SYNC) begin
      synchro_register_q <= bus.wdata[5:0];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      phase_mode_q <= `PTU_PHASE_RST;
    end else if (bus.wr && bus.addr == `PTU_OFF_PHASE) begin
      // channels 0 and 3 have no phase counting
      phase_mode_q <= bus.wdata[5:0] & `PTU_PHASE_MASK;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      buffer_mode_q <= `PTU_BUFFER_RST;
    end else if (bus.wr && bus.addr == `PTU_OFF_BUFFER) begin
      buffer_mode_q <= bus.wdata[3:0];
    end
  end

  // sticky record of clears; a clear in the cycle of a write-1 clear wins
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      clear_flag_q <= `PTU_FLAG_RST;
    end else if (bus.wr && bus.addr == `PTU_OFF_CLRFLAG) begin
      clear_flag_q <= (clear_flag_q & ~bus.wdata[5:0]) | clear_q;
    end else begin
      clear_flag_q <= clear_flag_q | clear_q;
    end
  end

  // ---------------------------------------------------------------
  // register reads: data stand in the cycle after the strobe only
  // ---------------------------------------------------------------

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= 8'h00;
    end else if (!bus.rd) begin
      rdata_q <= 8'h00;
    end else if (is_ctrl(bus.addr)) begin
      rdata_q <= counter_control_q[bus.addr[2:0]];
    end else begin
      case (bus.addr)
        `PTU_OFF_SYNC: begin
          rdata_q <= {2'h0, synchro_register_q};
        end
        `PTU_OFF_PHASE: begin
          rdata_q <= {2'h0, phase_mode_q};
        end
        `PTU_OFF_BUFFER: begin
          rdata_q <= {4'h0, buffer_mode_q};
        end
        `PTU_OFF_CLRFLAG: begin
          rdata_q <= {2'h0, clear_flag_q};
        end
        default: begin
          rdata_q <= 8'h00;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // clear source selection
  // ---------------------------------------------------------------

  for (genvar c = 0; c < NCH; c++) begin : g_clr
    logic buf_c;
    logic buf_d;
    ptu_pkg::ptu_code_t code;
    assign code = counter_control_q[c][`PTU_CLR_HI:`PTU_CLR_LO];
    if (c == 0) begin : g_b0
      assign buf_c = buffer_mode_q[`PTU_BUF_A0];
      assign buf_d = buffer_mode_q[`PTU_BUF_B0];
    end else if (c == 3) begin : g_b3
      assign buf_c = buffer_mode_q[`PTU_BUF_A3];
      assign buf_d = buffer_mode_q[`PTU_BUF_B3];
    end else begin : g_bn
      assign buf_c = 1'b0;
      assign buf_d = 1'b0;
    end

    always_comb begin
      own_clear[c] = 1'b0;
      sync_pick[c] = 1'b0;
      case (code)
        3'h1: begin
          own_clear[c] = match.reg_a[c]; // R1 R7
        end
        3'h2: begin
          own_clear[c] = match.reg_b[c]; // R1 R7
        end
        3'h5: begin
          own_clear[c] = match.reg_c[c] & ~buf_c; // R2 R5
        end
        3'h6: begin
          own_clear[c] = match.reg_d[c] & ~buf_d; // R2 R5
        end
        3'h3: begin
          sync_pick[c] = 1'b1; // R3 R7
        end
        3'h7: begin
          sync_pick[c] = 1'b1; // R3
        end
        default: begin
          own_clear[c] = 1'b0; // R1
        end
      endcase
    end

    // only members of the synchro group follow, and only from other members
    wire [5:0] others = own_clear & synchro_register_q & ~(6'h01 << c); // R4
    assign clear_d[c] = own_clear[c] |
                        (sync_pick[c] & synchro_register_q[c] & (|others)); // R3 R4
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      clear_q <= 6'h00;
    end else begin
      clear_q <= clear_d;
    end
  end

  // ---------------------------------------------------------------
  // count clock selection
  // ---------------------------------------------------------------

  // tap index: 0 /4, 1 /16, 2 /64, 3 /256, 4 /1024, 5 /4096
  for (genvar c = 0; c < NCH; c++) begin : g_cnt
    ptu_pkg::ptu_code_t psc;
    logic [1:0] eg;
    assign psc = counter_control_q[c][`PTU_PSC_HI:`PTU_PSC_LO];
    assign eg = counter_control_q[c][`PTU_EDGE_HI:`PTU_EDGE_LO];

    always_comb begin
      count_d[c] = 1'b0;
      case (psc)
        3'h0: begin
          count_d[c] = 1'b1; // R8
        end
        3'h1: begin
          count_d[c] = edge_pick(tap[0], eg); // R8
        end
        3'h2: begin
          count_d[c] = edge_pick(tap[1], eg); // R8
        end
        3'h3: begin
          count_d[c] = edge_pick(tap[2], eg); // R8
        end
        3'h4: begin
          count_d[c] = edge_pick(pin_edge[0], eg); // R9 R10 R11 R12 R13 R14
        end
        3'h5: begin
          case (c)
            0, 1, 2: begin
              count_d[c] = edge_pick(pin_edge[1], eg); // R9 R10 R11
            end
            3: begin
              count_d[c] = edge_pick(tap[4], eg); // R12
            end
            default: begin
              count_d[c] = edge_pick(pin_edge[2], eg); // R13 R14
            end
          endcase
        end
        3'h6: begin
          case (c)
            0, 2: begin
              count_d[c] = edge_pick(pin_edge[2], eg); // R9 R11
            end
            4: begin
              count_d[c] = edge_pick(tap[4], eg); // R13
            end
            default: begin
              count_d[c] = edge_pick(tap[3], eg); // R10 R12 R14
            end
          endcase
        end
        default: begin
          // overflow sources ignore the edge setting
          case (c)
            0, 5: begin
              count_d[c] = edge_pick(pin_edge[3], eg); // R9 R14
            end
            1: begin
              count_d[c] = channel_two_wrap; // R10
            end
            2: begin
              count_d[c] = edge_pick(tap[4], eg); // R11
            end
            3: begin
              count_d[c] = edge_pick(tap[5], eg); // R12
            end
            default: begin
              count_d[c] = channel_five_wrap; // R13
            end
          endcase
        end
      endcase
      if (phase_mode_q[c]) begin
        count_d[c] = phase_count[c]; // R15
      end
    end
  end

  // selection is expected to change only while the counter is stopped
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count_en_q <= 6'h00;
    end else begin
      count_en_q <= count_d; // R17
    end
  end

endmodule

//--- bench/ptu_far_side.sv
// far-side model: external clock pins and neighbouring channel wraps
`timescale 1ns/1ns
module ptu_far_side (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic run,
  output logic [3:0] ext_clock_pin,
  output logic channel_two_wrap,
  output logic channel_five_wrap
);
  logic [5:0] cnt_q;
  // pins stand still while stopped; each pin runs at half the rate of the one below
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= 6'h00;
    end else if (run) begin
      cnt_q <= cnt_q + 6'h01;
    end
  end
  assign ext_clock_pin = cnt_q[5:2];
  assign channel_two_wrap = run && cnt_q[3:0] == 4'h0;
  assign channel_five_wrap = run && cnt_q[4:0] == 5'h00;
endmodule

//--- bench/ptu_clock_clear_sva.sv
// assertions on the clock and clear selection ports
`timescale 1ns/1ns
module ptu_clock_clear_sva (
  input wire logic clk,
  input wire logic reset_n,
  input ptu_pkg::ptu_bus_s bus,
  input wire logic [7:0] rdata_q,
  input ptu_pkg::ptu_match_s match,
  input wire logic [5:0] phase_count,
  input wire logic channel_two_wrap,
  input wire logic [5:0] count_en_q,
  input wire logic [5:0] clear_q
);
  // shadow of the written selections, rebuilt from bus writes
  logic [7:0] ctl_q [6];
  logic [5:0] sy_q;
  logic [5:0] ph_q;
  logic [3:0] bf_q;
  wire [2:0] c0 = ctl_q[0][7:5];
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctl_q <= '{default: 8'h00};
      sy_q <= 6'h00;
      ph_q <= 6'h00;
      bf_q <= 4'h0;
    end else if (bus.wr) begin
      case (bus.addr)
        4'h6: sy_q <= bus.wdata[5:0];
        4'h7: ph_q <= bus.wdata[5:0];
        4'h8: bf_q <= bus.wdata[3:0];
        4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'hE, 4'hF: ;
        default: ctl_q[bus.addr[2:0]] <= bus.wdata;
      endcase
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_clr_a; match.reg_a[0] && c0 == 3'h1 |=> clear_q[0]; endproperty
  a_clr_a: assert property (p_clr_a) else $error("ch0 missed clear on A");
  property p_clr_off; c0 == 3'h0 || c0 == 3'h4 |=> !clear_q[0]; endproperty
  a_clr_off: assert property (p_clr_off) else $error("ch0 cleared while off");
  property p_clr_c; match.reg_c[0] && c0 == 3'h5 && !bf_q[0] |=> clear_q[0]; endproperty
  a_clr_c: assert property (p_clr_c) else $error("ch0 missed clear on C");
  property p_buf_d; c0 == 3'h6 && bf_q[1] |=> !clear_q[0]; endproperty
  a_buf_d: assert property (p_buf_d) else $error("buffered D cleared");
  property p_rsv; $past(bus.rd) && $past(bus.addr) == 4'h1 |-> !rdata_q[7]; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bit read 1");
  property p_clr_b1; match.reg_b[1] && ctl_q[1][6:5] == 2'h2 |=> clear_q[1]; endproperty
  a_clr_b1: assert property (p_clr_b1) else $error("ch1 missed clear on B");
  // three cycles: the registered enable lags the selection by one edge, also after reset
  property p_phi1; ctl_q[0][2:0] == 3'h0 [*3] |-> count_en_q[0]; endproperty
  a_phi1: assert property (p_phi1) else $error("phi/1 count gap");
  property p_wrap; ctl_q[1][2:0] == 3'h7 && !ph_q[1] && channel_two_wrap |=> count_en_q[1];
  endproperty
  a_wrap: assert property (p_wrap) else $error("ch1 missed wrap count");
  property p_phase; ph_q[1] |=> count_en_q[1] == $past(phase_count[1]); endproperty
  a_phase: assert property (p_phase) else $error("phase count not followed");
  property p_nosync; ctl_q[1][6:5] == 2'h3 && !sy_q[1] |=> !clear_q[1]; endproperty
  a_nosync: assert property (p_nosync) else $error("unsynced ch1 cleared");
  property p_sync;
    ctl_q[3][7:5] == 3'h7 && sy_q[3] && sy_q[0] && c0 == 3'h1 && match.reg_a[0] |=> clear_q[3];
  endproperty
  a_sync: assert property (p_sync) else $error("ch3 missed sync clear");
  c_sync: cover property (clear_q[3]);
  c_phase: cover property (ph_q[1] && count_en_q[1]);
  c_wrap: cover property (channel_two_wrap && count_en_q[1]);
endmodule
bind ptu_clock_clear ptu_clock_clear_sva u_sva (.clk, .reset_n, .bus, .rdata_q, .match,
  .phase_count, .channel_two_wrap, .count_en_q, .clear_q);

//--- bench/tb_top.sv
// self-checking bench for the clock and clear selection block
`timescale 1ns/1ns
module tb_top;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic run = 1'b0;
  ptu_pkg::ptu_bus_s bus = '0;
  ptu_pkg::ptu_match_s match = '0;
  logic [5:0] phase_count = 6'h00;
  logic [3:0] pins;
  logic w2;
  logic w5;
  logic [7:0] rdata_q;
  logic [5:0] count_en_q;
  logic [5:0] clear_q;
  int n_fail = 0;
  int cmp_count = 0;
  // addr, ctrl byte, long window flag, expected pulses
  localparam logic [27:0] SEL[32] = '{
    28'h0000100, 28'h0010040, 28'h0020010, 28'h0030004, 28'h0040020, 28'h0050010,
    28'h0060008, 28'h0070004, 28'h0090040, 28'h0110080, 28'h0140040, 28'h1040020,
    28'h1050010, 28'h1061010, 28'h1070010, 28'h2040020, 28'h2050010, 28'h2060008,
    28'h2071004, 28'h3010040, 28'h3040020, 28'h3051004, 28'h3061010, 28'h3071001,
    28'h4040020, 28'h4050008, 28'h4061004, 28'h4070008, 28'h5040020, 28'h5050008,
    28'h5061010, 28'h5070004};
  always #50 clk = ~clk;
  ptu_clock_clear u_dut (.clk, .reset_n, .bus, .rdata_q, .ext_clock_pin(pins), .match,
    .phase_count, .channel_two_wrap(w2), .channel_five_wrap(w5), .count_en_q, .clear_q);
  ptu_far_side u_far (.clk, .reset_n, .run, .ext_clock_pin(pins), .channel_two_wrap(w2),
    .channel_five_wrap(w5));
  task automatic chk(input string nm, input logic [12:0] e, input logic [12:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("MISMATCH %s exp %h got %h", nm, e, g);
      n_fail++;
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    bus <= '0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    bus <= '0;
    #1;
    chk("rdata", {5'h00, e}, {5'h00, rdata_q});
  endtask
  // settle first so pulses of the previous source do not leak into the window
  task automatic cnt(input int ch, input int w, input logic [12:0] e);
    logic [12:0] n;
    n = 13'h0000;
    repeat (8) @(posedge clk);
    repeat (w) begin
      @(posedge clk);
      #1;
      n += 13'(count_en_q[ch] === 1'b1);
    end
    chk("count", e, n);
  endtask
  task automatic clr(input int s, input int ch, input logic [5:0] e);
    @(posedge clk);
    match <= 24'h000001 << ((3 - s) * 6 + ch);
    @(posedge clk);
    match <= '0;
    #1;
    chk("clear", {7'h00, e}, {7'h00, clear_q});
  endtask
  task automatic tally_and_finish;
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    n_fail++;
    tally_and_finish;
  end
  initial begin
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    run <= 1'b1;
    rd(4'h0, 8'h00);
    wr(4'h1, 8'hFF);
    rd(4'h1, 8'h7F);
    wr(4'hA, 8'h55);
    rd(4'hA, 8'h00);
    foreach (SEL[i]) begin
      wr(SEL[i][27:24], SEL[i][23:16]);
      cnt(SEL[i][27:24], SEL[i][12] ? 4096 : 256, {1'b0, SEL[i][11:0]});
    end
    wr(4'h0, 8'h20);
    wr(4'h1, 8'h40);
    clr(0, 0, 6'h01);
    clr(1, 0, 6'h00);
    clr(1, 1, 6'h02);
    wr(4'h0, 8'h80);
    clr(0, 0, 6'h00);
    wr(4'h0, 8'hA0);
    clr(2, 0, 6'h01);
    wr(4'h0, 8'hC0);
    clr(3, 0, 6'h01);
    wr(4'h8, 8'h02);
    clr(3, 0, 6'h00);
    wr(4'h0, 8'h20);
    wr(4'h1, 8'h60);
    wr(4'h3, 8'hE0);
    wr(4'h6, 8'h09);
    clr(0, 0, 6'h09);
    wr(4'h6, 8'h0B);
    clr(0, 0, 6'h0B);
    wr(4'h1, 8'h00);
    wr(4'h7, 8'h02);
    cnt(1, 256, 13'h0000);
    @(posedge clk);
    phase_count <= 6'h02;
    cnt(1, 256, 13'h0100);
    rd(4'h9, 8'h0B);
    wr(4'h9, 8'hFF);
    rd(4'h9, 8'h00);
    rd(4'h6, 8'h0B);
    rd(4'h8, 8'h02);
    wr(4'h7, 8'hFF);
    rd(4'h7, 8'h36);
    tally_and_finish;
  end
endmodule
